// ==== gpio_bank_consts.svh ====
// offsets, bit layouts, widths and reset values of the gpio data banks
// assumes it is included once per file by its bare name
`ifndef GPIO_BANK_CONSTS_SVH
`define GPIO_BANK_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_BANK_FIRST 6'h0C
`define IDX_BANK_SECOND 6'h0D
`define IDX_BANK_THIRD 6'h0E
`define IDX_BANK_FOURTH 6'h0F
`define IDX_BANK_FIFTH 6'h10

`define BANK_COUNT 5
`define BANK_WIDTH 8
`define PORT_COUNT 40

// ports that are gpio by default, and ports that are gpio only through alternate select
`define MASK_PLAIN 40'hFF_FFFF_0F0E
`define MASK_ALT_ONLY 40'h00_0000_00C0

`define DATA_RESET 1'b0
`define DAT_WIDTH 32
`define ADR_WIDTH 8
`define SEL_WIDTH 4

`endif

// ==== gpio_bank_pkg.sv ====
// types shared by the gpio data bank files
// assumes gpio_bank_consts.svh is on the include path
`include "gpio_bank_consts.svh"

package gpio_bank_pkg;
  typedef enum {
    bank_first,
    bank_second,
    bank_third,
    bank_fourth,
    bank_fifth,
    bank_none
  } bank_e;

  typedef logic [`PORT_COUNT-1:0] port_vec_t;
endpackage

// ==== gpio_data_register_bank.sv ====
// gpio data register bank: five 8-bit data registers on a wishbone slave
// assumes direction, polarity and alternate select come from config space
//
// Function
// - each port owns exactly one data bit
// - five 8-bit banks hold the port bits
// - input port read returns pin level
// - output port drives the written value
// - value latched at input read and output write
// - first three banks at 0C, 0D, 0E
// - fourth at 0F; fifth moved to 10
// - first and second bank bit layouts fixed
// - alternate functions selected outside, per pin
// - banks three to five: serial modem lines
// - input write ignored; output read returns data
`include "gpio_bank_consts.svh"

module gpio_data_register_bank
  import gpio_bank_pkg::*;
#(
  parameter int PORTS = `PORT_COUNT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ADR_WIDTH-1:0] wb_adr_i,
  input wire logic [`SEL_WIDTH-1:0] wb_sel_i,
  input wire logic [`DAT_WIDTH-1:0] wb_dat_i,
  output logic [`DAT_WIDTH-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [PORTS-1:0] port_dir_in_i,
  input wire logic [PORTS-1:0] port_invert_i,
  input wire logic [PORTS-1:0] port_alt_sel_i,
  input wire logic [PORTS-1:0] pin_i,
  output logic [PORTS-1:0] pin_o,
  output logic [PORTS-1:0] pin_oe_o
);

  // ************************************************************
  // bus handshake and decode
  // ************************************************************
  logic ack_q;
  logic take;
  logic [5:0] index;
  bank_e bank;
  logic [PORTS-1:0] active;
  logic [PORTS-1:0] acc;
  logic [PORTS-1:0] rbit;
  logic [PORTS-1:0] data_vec;
  logic [`BANK_WIDTH-1:0] rbyte;
  logic [`DAT_WIDTH-1:0] dat_q;
  logic [`DAT_WIDTH-1:0] dat_d;

  // one access per request; ack drops the cycle after it is given
  assign take = wb_cyc_i && wb_stb_i && !ack_q;
  assign index = wb_adr_i[`ADR_WIDTH-1:2];

  always_comb begin
    case (index)
      `IDX_BANK_FIRST: bank = bank_first;
      `IDX_BANK_SECOND: bank = bank_second;
      `IDX_BANK_THIRD: bank = bank_third;
      `IDX_BANK_FOURTH: bank = bank_fourth;
      `IDX_BANK_FIFTH: bank = bank_fifth;
      default: bank = bank_none;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  assign wb_ack_o = ack_q;

  // ************************************************************
  // port cells
  // ************************************************************
  // a port is live when it is plain gpio with no alternate selected,
  // or an alternate-only slot whose select picks gpio
  assign active = (`MASK_PLAIN & ~port_alt_sel_i)
                | (`MASK_ALT_ONLY & port_alt_sel_i);

  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++) begin : g_port
      assign acc[gi] = take && (int'(bank) == gi / `BANK_WIDTH)
                     && (!wb_we_i || wb_sel_i[0]);
      gpio_port_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .active_i(active[gi]),
        .acc_i(acc[gi]),
        .we_i(wb_we_i),
        .wbit_i(wb_dat_i[gi % `BANK_WIDTH]),
        .dir_in_i(port_dir_in_i[gi]),
        .invert_i(port_invert_i[gi]),
        .pin_i(pin_i[gi]),
        .pin_o(pin_o[gi]),
        .pin_oe_o(pin_oe_o[gi]),
        .data_o(data_vec[gi]),
        .rbit_o(rbit[gi])
      );
    end
  endgenerate

  // ************************************************************
  // read data
  // ************************************************************
  always_comb begin
    case (bank)
      bank_first: rbyte = rbit[7:0];
      bank_second: rbyte = rbit[15:8];
      bank_third: rbyte = rbit[23:16];
      bank_fourth: rbyte = rbit[31:24];
      bank_fifth: rbyte = rbit[39:32];
      default: rbyte = 8'h00;
    endcase
    dat_d = {24'h00_0000, rbyte};
  end

  // read value is captured at the access edge, so it holds through ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (take && !wb_we_i) begin
      dat_q <= dat_d;
    end else if (take) begin
      dat_q <= 32'h0000_0000;
    end
  end

  assign wb_dat_o = dat_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [PORTS-1:0] pin_lvl;
  assign pin_lvl = pin_i ^ port_invert_i;

  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o
  ) else $error("request not acknowledged next cycle");

  a_ack_has_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)
  ) else $error("ack with no request");

  a_reserved_zero: assert property (
    (data_vec[0] == 1'b0) && (data_vec[5:4] == 2'b00) && (data_vec[15:12] == 4'h0)
  ) else $error("reserved data bit holds a one");

  a_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000
  ) else $error("bits above the byte not zero");

  a_unmapped_read: assert property (
    take && !wb_we_i && bank == bank_none |=> wb_ack_o && wb_dat_o == 32'h0000_0000
  ) else $error("unmapped read returned data");

  a_write_reaches_pin: assert property (
    take && wb_we_i && wb_sel_i[0] && bank == bank_third
      && port_dir_in_i[23:16] == 8'h00 && port_alt_sel_i[23:16] == 8'h00
      |=> pin_o[23:16] == ($past(wb_dat_i[7:0]) ^ port_invert_i[23:16])
        && pin_oe_o[23:16] == 8'hFF
  ) else $error("written value not driven on pin");

  a_input_read_pin: assert property (
    take && !wb_we_i && bank == bank_fourth && port_dir_in_i[31:24] == 8'hFF
      && port_alt_sel_i[31:24] == 8'h00
      |=> wb_ack_o && wb_dat_o[7:0] == $past(pin_lvl[31:24])
  ) else $error("input read did not return pin level");

  a_input_write_ignored: assert property (
    take && wb_we_i && bank == bank_fifth && port_dir_in_i[39:32] == 8'hFF
      |=> $stable(data_vec[39:32])
  ) else $error("write changed an input port");

  a_output_readback: assert property (
    take && !wb_we_i && bank == bank_second && port_dir_in_i[11:8] == 4'h0
      && port_alt_sel_i[11:8] == 4'h0
      |=> wb_dat_o[3:0] == $past(data_vec[11:8])
  ) else $error("output read not last written value");

  a_oe_only_output: assert property (
    (pin_oe_o & port_dir_in_i) == '0
  ) else $error("pin driven while set as input");

  a_alt_releases_pin: assert property (
    (pin_oe_o & port_alt_sel_i & `MASK_PLAIN) == '0
  ) else $error("gpio drives a pin given to its alternate");

  a_reset_state: assert property (
    $past(rst_i) |-> data_vec == '0 && wb_dat_o == 32'h0000_0000 && !wb_ack_o
  ) else $error("state not cleared by reset");

  a_data_on_access: assert property (
    !$past(rst_i) && !$past(take) |-> $stable(data_vec)
  ) else $error("data bit changed with no access");

  a_rdata_hold: assert property (
    !$past(rst_i) && !$past(take) |-> $stable(wb_dat_o)
  ) else $error("read data changed with no access");

  a_first_write_bits: assert property (
    take && wb_we_i && wb_sel_i[0] && bank == bank_first
      && port_dir_in_i[3:1] == 3'b000 && port_alt_sel_i[3:1] == 3'b000
      |=> data_vec[3:1] == $past(wb_dat_i[3:1]) && data_vec[0] == 1'b0
  ) else $error("first bank write not stored");

  a_second_write_bits: assert property (
    take && wb_we_i && wb_sel_i[0] && bank == bank_second
      && port_dir_in_i[11:8] == 4'h0 && port_alt_sel_i[11:8] == 4'h0
      |=> data_vec[11:8] == $past(wb_dat_i[3:0]) && data_vec[15:12] == 4'h0
  ) else $error("second bank write not stored");

  a_alt_slot_write: assert property (
    take && wb_we_i && wb_sel_i[0] && bank == bank_first
      && port_dir_in_i[7:6] == 2'b00 && port_alt_sel_i[7:6] == 2'b11
      |=> data_vec[7:6] == $past(wb_dat_i[7:6])
  ) else $error("alternate slot write not stored");

  a_alt_slot_idle: assert property (
    take && wb_we_i && bank == bank_first && port_alt_sel_i[7:6] == 2'b00
      |=> $stable(data_vec[7:6])
  ) else $error("write reached an unselected slot");

  a_fourth_write: assert property (
    take && wb_we_i && wb_sel_i[0] && bank == bank_fourth
      && port_dir_in_i[31:24] == 8'h00 && port_alt_sel_i[31:24] == 8'h00
      |=> data_vec[31:24] == $past(wb_dat_i[7:0]) && $stable(data_vec[39:32])
  ) else $error("fourth bank write misplaced");

  a_fifth_write: assert property (
    take && wb_we_i && wb_sel_i[0] && bank == bank_fifth
      && port_dir_in_i[39:32] == 8'h00 && port_alt_sel_i[39:32] == 8'h00
      |=> data_vec[39:32] == $past(wb_dat_i[7:0]) && $stable(data_vec[31:24])
  ) else $error("fifth bank write misplaced");

  a_lane_gates_write: assert property (
    take && wb_we_i && !wb_sel_i[0] |=> $stable(data_vec)
  ) else $error("write without lane zero changed data");

  a_unmapped_write: assert property (
    take && wb_we_i && bank == bank_none |=> $stable(data_vec)
  ) else $error("unmapped write changed data");

  a_output_read_keeps: assert property (
    take && !wb_we_i && port_dir_in_i == '0 |=> $stable(data_vec)
  ) else $error("read of output ports changed data");

  a_input_read_latch: assert property (
    take && !wb_we_i && bank == bank_third && port_dir_in_i[23:16] == 8'hFF
      && port_alt_sel_i[23:16] == 8'h00
      |=> data_vec[23:16] == $past(pin_lvl[23:16])
  ) else $error("input read did not latch pin level");

  a_modem_bank_read: assert property (
    take && !wb_we_i && bank == bank_fifth && port_dir_in_i[39:32] == 8'hFF
      && port_alt_sel_i[39:32] == 8'h00
      |=> wb_ack_o && wb_dat_o[7:0] == $past(pin_lvl[39:32])
  ) else $error("modem bank read did not return pin level");

  a_first_input_read: assert property (
    take && !wb_we_i && bank == bank_first && port_dir_in_i[7:0] == 8'hFF
      && port_alt_sel_i[7:0] == 8'h00
      |=> wb_dat_o[7:0] == ($past(pin_lvl[7:0]) & 8'(`MASK_PLAIN))
  ) else $error("first bank input read wrong");

  a_second_input_read: assert property (
    take && !wb_we_i && bank == bank_second && port_dir_in_i[15:8] == 8'hFF
      && port_alt_sel_i[15:8] == 8'h00
      |=> wb_dat_o[7:0] == {4'h0, $past(pin_lvl[11:8])}
  ) else $error("second bank input read wrong");

  a_reserved_read_zero: assert property (
    take && !wb_we_i && bank == bank_first |=> wb_dat_o[0] == 1'b0 && wb_dat_o[5:4] == 2'b00
  ) else $error("reserved bit of first bank read as one");

  a_reserved_upper_nibble: assert property (
    take && !wb_we_i && bank == bank_second |=> wb_dat_o[7:4] == 4'h0
  ) else $error("reserved nibble of second bank read as one");

  a_reserved_undriven: assert property (
    (pin_oe_o & ~(`MASK_PLAIN | `MASK_ALT_ONLY)) == '0
  ) else $error("reserved position drives a pin");

  a_output_drives_pin: assert property (
    (~pin_oe_o & `MASK_PLAIN & ~port_alt_sel_i & ~port_dir_in_i) == '0
  ) else $error("plain output port not driven");

  a_alt_slot_undriven: assert property (
    (pin_oe_o & `MASK_ALT_ONLY & ~port_alt_sel_i) == '0
  ) else $error("unselected alternate slot drives a pin");

  a_modem_bank_drive: assert property (
    port_alt_sel_i[39:16] == 24'h00_0000 |-> pin_oe_o[39:16] == ~port_dir_in_i[39:16]
  ) else $error("modem bank port drive wrong");

endmodule // gpio_data_register_bank

// ==== gpio_data_register_bank_test.sv ====
// self-checking bench for the gpio data register bank
// assumes gpio_bank_consts.svh and gpio_bank_pkg.sv compile first
`include "gpio_bank_consts.svh"

module gpio_data_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // stimulus signals
  // ****************
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [39:0] dir = 40'h00_0000_0000;
  logic [39:0] inv = 40'h00_00FF_0000;
  logic [39:0] alt = 40'h00_0000_0000;
  logic [39:0] pin = 40'h5A_C396_0FFA;
  logic [39:0] pout;
  logic [39:0] poe;
  int err_count = 0;
  int n_compared = 0;

  always #10 clk_i = ~clk_i;

  gpio_data_register_bank uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_dir_in_i(dir), .port_invert_i(inv), .port_alt_sel_i(alt), .pin_i(pin),
    .pin_o(pout), .pin_oe_o(poe)
  );

  // ****************
  // shared tasks
  // ****************
  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function logic [7:0] badr(input int b);
    return {6'(`IDX_BANK_FIRST + b), 2'b00};
  endfunction

  function logic [7:0] mb(input int b);
    return 8'(`MASK_PLAIN >> (8 * b));
  endfunction

  // one classic cycle; waits for ack under a bound
  task bus(input logic w, input logic [7:0] a, input logic [3:0] s,
           input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_count++;
      wrap_up;
    end
    r = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask

  task rd(input int b, output logic [31:0] r);
    bus(1'b0, badr(b), 4'h1, 32'h0000_0000, r);
  endtask

  task wr(input int b, input logic [7:0] v);
    logic [31:0] x;
    bus(1'b1, badr(b), 4'h1, {24'h00_0000, v}, x);
  endtask

  // ****************
  // scenarios
  // ****************
  task t_reset;
    logic [31:0] r;
    for (int b = 0; b < 5; b++) begin
      rd(b, r);
      chk(40'(r), 40'h0);
    end
    chk(pout, inv);
    chk(poe, `MASK_PLAIN);
  endtask

  task t_write;
    logic [31:0] r;
    for (int b = 0; b < 5; b++) begin
      wr(b, 8'hFF);
      rd(b, r);
      chk(40'(r), 40'(mb(b)));
    end
    chk(pout, `MASK_PLAIN ^ inv);
  endtask

  task t_misc;
    logic [31:0] r;
    bus(1'b1, badr(2), 4'h0, 32'h0000_0000, r);
    rd(2, r);
    chk(40'(r), 40'h0000_00FF);
    bus(1'b1, 8'h44, 4'h1, 32'h0000_00FF, r);
    bus(0, 8'h44, 4'h1, 32'h0000_0000, r);
    chk(40'(r), 40'h0);
    wr(3, 8'h00);
    rd(4, r);
    chk(40'(r), 40'h0000_00FF);
    alt <= 40'h00_0000_00C0;
    wr(0, 8'hCE);
    rd(0, r);
    chk(40'(r), 40'h0000_00CE);
    chk(poe, `MASK_PLAIN | `MASK_ALT_ONLY);
    alt <= 40'h00_0000_0000;
    wr(3, 8'hFF);
  endtask

  task t_input;
    logic [31:0] r;
    logic [39:0] lv;
    dir <= '1;
    for (int b = 0; b < 5; b++) wr(b, 8'h00);
    chk(pout, (`MASK_PLAIN | `MASK_ALT_ONLY) ^ inv);
    chk(poe, 40'h0);
    lv = pin ^ inv;
    for (int b = 0; b < 5; b++) begin
      rd(b, r);
      chk(40'(r), 40'(mb(b) & 8'(lv >> (8 * b))));
    end
    pin <= ~pin;
    rd(2, r);
    chk(40'(r), 40'(8'(~lv >> 16)));
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_write;
    t_misc;
    t_input;
    wrap_up;
  end
endmodule // gpio_data_register_bank_test

// ==== gpio_port_cell.sv ====
// one gpio port: its single data bit, pin drive and read value
// assumes a one-cycle access strobe from the register decode
`include "gpio_bank_consts.svh"

module gpio_port_cell
  import gpio_bank_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic active_i,
  input wire logic acc_i,
  input wire logic we_i,
  input wire logic wbit_i,
  input wire logic dir_in_i,
  input wire logic invert_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic data_o,
  output logic rbit_o
);

  // ************************************************************
  // data bit
  // ************************************************************
  logic data_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= `DATA_RESET;
    end else if (acc_i && active_i) begin
      if (!we_i && dir_in_i) begin
        data_q <= pin_i ^ invert_i;
      end else if (we_i && !dir_in_i) begin
        data_q <= wbit_i;
      end
    end
  end

  // ************************************************************
  // pin and read path
  // ************************************************************
  // an input reads the live pin so the value returned is the one latched
  always_comb begin
    rbit_o = 1'b0;
    if (active_i) begin
      rbit_o = dir_in_i ? (pin_i ^ invert_i) : data_q;
    end
  end

  assign pin_o = data_q ^ invert_i;
  assign pin_oe_o = active_i && !dir_in_i;
  assign data_o = data_q;

endmodule // gpio_port_cell
